// >>> afc_pkg.sv
// Constants, types and helpers shared by the function configuration block
// Contract
// - Transfer bit copies staged values to active
// - Power field: 00 normal, 01 down, 10 standby
// - Power bit 5 picks pin-forced down or standby
// - Clock bit 0 enables stabiliser, resets 0x01
// - Divide ratio field divides by value plus one
// - Phase field delays divided clock 0-7 cycles
// - Nonzero divide ratio forces stabiliser on
// - Test mode replaces samples on channel outputs
// - Bit 7: repeat user pattern or once
// - Bits 5/4 hold long/short PN in reset
// - Code 0110 PN, code 0111 one/zero toggle
// - Offset adds twos-complement +31 to -32 LSBs
// - Channel index bits steer per-channel writes
package afc_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_CLK_STAB = 8'h09;
  localparam logic [7:0] ADDR_CLK_DIV = 8'h0B;
  localparam logic [7:0] ADDR_TEST = 8'h0D;
  localparam logic [7:0] ADDR_OFFSET = 8'h10;
  localparam logic [7:0] ADDR_USER_LSB = 8'h19;
  localparam logic [7:0] ADDR_USER_MSB = 8'h1A;
  localparam logic [7:0] ADDR_TRANSFER = 8'hFF;
  // ==========================================
  // Reset values
  localparam logic [7:0] RST_CHAN_INDEX = 8'h03;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_CLK_STAB = 8'h01;
  localparam logic [7:0] RST_CLK_DIV = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_USER = 8'h00;
  // ==========================================
  // Field positions
  localparam int XFER_BIT = 0;
  localparam int PWR_MODE_LSB = 0;
  localparam int PWR_PIN_BIT = 5;
  localparam int DCS_BIT = 0;
  localparam int DIV_RATIO_LSB = 0;
  localparam int DIV_PHASE_LSB = 3;
  localparam int TEST_SEL_LSB = 0;
  localparam int TEST_SHORT_RST_BIT = 4;
  localparam int TEST_LONG_RST_BIT = 5;
  localparam int TEST_SINGLE_BIT = 7;
  localparam int OFFSET_LSB = 0;
  localparam int SAMPLE_W = 12;
  // ==========================================
  // Codes and seeds
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;
  localparam logic [1:0] PWR_STANDBY = 2'h2;
  localparam logic [3:0] TEST_OFF = 4'h0;
  localparam logic [3:0] TEST_PN_SHORT = 4'h5;
  localparam logic [3:0] TEST_PN_LONG = 4'h6;
  localparam logic [3:0] TEST_TOGGLE = 4'h7;
  localparam logic [3:0] TEST_USER = 4'h8;
  localparam logic [22:0] PN_LONG_SEED = 23'h7FFFFF;
  localparam logic [8:0] PN_SHORT_SEED = 9'h1FF;
  localparam logic [11:0] SAMPLE_MAX = 12'h7FF;
  localparam logic [11:0] SAMPLE_MIN = 12'h800;

  typedef enum logic [1:0] {
    PAT_SEND = 2'h0,
    PAT_ZERO = 2'h1
  } afc_pat_e;

  // Register view of whichever channel the index selects, A first
  function automatic logic [7:0] afc_pick_chan(input logic [1:0] idx,
                                               input logic [7:0] chA,
                                               input logic [7:0] chB);
    afc_pick_chan = idx[0] ? chA : (idx[1] ? chB : 8'h00);
  endfunction

  // Sample plus signed offset, clamped to the 12-bit code range
  function automatic logic [11:0] afc_sat_add(input logic [11:0] smp,
                                              input logic [5:0] off);
    logic [12:0] sum;
    sum = {smp[11], smp} + {{7{off[5]}}, off};
    if (sum[12] != sum[11]) begin
      afc_sat_add = sum[12] ? SAMPLE_MIN : SAMPLE_MAX;
    end else begin
      afc_sat_add = sum[11:0];
    end
  endfunction
endpackage

// >>> afc_chan_if.sv
// Active per-channel settings passed from the register bank to a data path
`timescale 1ns/10ps
interface afc_chan_if;
  logic [7:0] testCtl;
  logic [5:0] offset;
  logic [15:0] userPat;
  logic restart;
  modport src (output testCtl, output offset, output userPat, output restart);
  modport dst (input testCtl, input offset, input userPat, input restart);
endinterface

// >>> afc_channel_path.sv
// Per-channel output path: test pattern generators and offset correction
`timescale 1ns/10ps
module afc_channel_path (
  input wire logic core_clk,
  input wire logic reset,
  afc_chan_if.dst cfg,
  input wire logic [11:0] sampleIn,
  output logic [11:0] dataOut
);
  // ==========================================
  // State
  logic [22:0] pnLong_ff;
  logic [22:0] nxt_pnLong;
  logic [8:0] pnShort_ff;
  logic [8:0] nxt_pnShort;
  logic toggle_ff;
  logic nxt_toggle;
  afc_pkg::afc_pat_e patState_ff;
  afc_pkg::afc_pat_e nxt_patState;
  logic [11:0] dataOut_ff;
  logic [11:0] nxt_dataOut;
  logic [3:0] sel;
  logic singleShot;

  assign sel = cfg.testCtl[afc_pkg::TEST_SEL_LSB +: 4];
  assign singleShot = cfg.testCtl[afc_pkg::TEST_SINGLE_BIT];

  // ==========================================
  // Next values
  always_comb begin
    nxt_pnLong = {pnLong_ff[21:0], pnLong_ff[22] ^ pnLong_ff[17]};
    nxt_pnShort = {pnShort_ff[7:0], pnShort_ff[8] ^ pnShort_ff[4]};
    if (cfg.testCtl[afc_pkg::TEST_LONG_RST_BIT]) begin
      nxt_pnLong = afc_pkg::PN_LONG_SEED;
    end
    if (cfg.testCtl[afc_pkg::TEST_SHORT_RST_BIT]) begin
      nxt_pnShort = afc_pkg::PN_SHORT_SEED;
    end
    nxt_toggle = ~toggle_ff;
    nxt_patState = patState_ff;
    case (patState_ff)
      afc_pkg::PAT_SEND: begin
        if (sel == afc_pkg::TEST_USER && singleShot && !cfg.restart) begin
          nxt_patState = afc_pkg::PAT_ZERO;
        end
      end
      afc_pkg::PAT_ZERO: begin
        if (cfg.restart || !singleShot || sel != afc_pkg::TEST_USER) begin
          nxt_patState = afc_pkg::PAT_SEND;
        end
      end
      default: nxt_patState = afc_pkg::PAT_SEND;
    endcase
    case (sel)
      afc_pkg::TEST_OFF: nxt_dataOut = afc_pkg::afc_sat_add(sampleIn, cfg.offset);
      afc_pkg::TEST_PN_SHORT: nxt_dataOut = {pnShort_ff, pnShort_ff[8:6]};
      afc_pkg::TEST_PN_LONG: nxt_dataOut = pnLong_ff[22:11];
      afc_pkg::TEST_TOGGLE: nxt_dataOut = {12{toggle_ff}};
      afc_pkg::TEST_USER: begin
        nxt_dataOut = (patState_ff == afc_pkg::PAT_SEND) ? cfg.userPat[15:4] : 12'h000;
      end
      default: nxt_dataOut = 12'h000;
    endcase
  end

  // ==========================================
  // Registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pnLong_ff <= afc_pkg::PN_LONG_SEED;
      pnShort_ff <= afc_pkg::PN_SHORT_SEED;
      toggle_ff <= 1'b0;
      patState_ff <= afc_pkg::PAT_SEND;
      dataOut_ff <= 12'h000;
    end else begin
      pnLong_ff <= nxt_pnLong;
      pnShort_ff <= nxt_pnShort;
      toggle_ff <= nxt_toggle;
      patState_ff <= nxt_patState;
      dataOut_ff <= nxt_dataOut;
    end
  end

  assign dataOut = dataOut_ff;
endmodule

// >>> afc_function_config.sv
// Function configuration register bank with staged transfer and clock divider
`timescale 1ns/10ps
module afc_function_config (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic pdPin,
  input wire logic [11:0] sampleA,
  input wire logic [11:0] sampleB,
  output logic [11:0] dataOutA,
  output logic [11:0] dataOutB,
  output logic [1:0] pwrModeA,
  output logic [1:0] pwrModeB,
  output logic dcsEnable,
  output logic divClkOut
);
  // ==========================================
  // Channel index and transfer control
  logic [1:0] chanIdx_ff;
  logic [1:0] nxt_chanIdx;
  logic xferPend_ff;
  logic nxt_xferPend;

  // ==========================================
  // Staged register copies
  logic [7:0] stgPower_ff [2];
  logic [7:0] nxt_stgPower [2];
  logic [7:0] stgTest_ff [2];
  logic [7:0] nxt_stgTest [2];
  logic [7:0] stgOffset_ff [2];
  logic [7:0] nxt_stgOffset [2];
  logic [7:0] stgStab_ff;
  logic [7:0] nxt_stgStab;
  logic [7:0] stgDiv_ff;
  logic [7:0] nxt_stgDiv;
  logic [15:0] stgUser_ff;
  logic [15:0] nxt_stgUser;

  // ==========================================
  // Active register copies
  logic [7:0] actPower_ff [2];
  logic [7:0] nxt_actPower [2];
  logic [7:0] actTest_ff [2];
  logic [7:0] nxt_actTest [2];
  logic [7:0] actOffset_ff [2];
  logic [7:0] nxt_actOffset [2];
  logic [7:0] actStab_ff;
  logic [7:0] nxt_actStab;
  logic [7:0] actDiv_ff;
  logic [7:0] nxt_actDiv;
  logic [15:0] actUser_ff;
  logic [15:0] nxt_actUser;
  logic applied_ff;
  logic nxt_applied;

  // ==========================================
  // Read port
  logic [7:0] regRdData_ff;
  logic [7:0] nxt_regRdData;

  // ==========================================
  // Register writes and staged transfer
  always_comb begin
    nxt_chanIdx = chanIdx_ff;
    nxt_xferPend = 1'b0;
    nxt_stgStab = stgStab_ff;
    nxt_stgDiv = stgDiv_ff;
    nxt_stgUser = stgUser_ff;
    for (int ch = 0; ch < 2; ch++) begin
      nxt_stgPower[ch] = stgPower_ff[ch];
      nxt_stgTest[ch] = stgTest_ff[ch];
      nxt_stgOffset[ch] = stgOffset_ff[ch];
    end
    if (regWrStb) begin
      case (regAddr)
        afc_pkg::ADDR_CHAN_INDEX: nxt_chanIdx = regWrData[1:0];
        afc_pkg::ADDR_CLK_STAB: nxt_stgStab = regWrData;
        afc_pkg::ADDR_CLK_DIV: nxt_stgDiv = regWrData;
        afc_pkg::ADDR_USER_LSB: nxt_stgUser[7:0] = regWrData;
        afc_pkg::ADDR_USER_MSB: nxt_stgUser[15:8] = regWrData;
        afc_pkg::ADDR_TRANSFER: nxt_xferPend = regWrData[afc_pkg::XFER_BIT];
        default: nxt_xferPend = 1'b0;
      endcase
      for (int ch = 0; ch < 2; ch++) begin
        if (chanIdx_ff[ch]) begin
          if (regAddr == afc_pkg::ADDR_POWER) begin
            nxt_stgPower[ch] = regWrData;
          end
          if (regAddr == afc_pkg::ADDR_TEST) begin
            nxt_stgTest[ch] = regWrData;
          end
          if (regAddr == afc_pkg::ADDR_OFFSET) begin
            nxt_stgOffset[ch] = regWrData;
          end
        end
      end
    end
  end

  always_comb begin
    nxt_applied = xferPend_ff;
    nxt_actStab = actStab_ff;
    nxt_actDiv = actDiv_ff;
    nxt_actUser = actUser_ff;
    for (int ch = 0; ch < 2; ch++) begin
      nxt_actPower[ch] = actPower_ff[ch];
      nxt_actTest[ch] = actTest_ff[ch];
      nxt_actOffset[ch] = actOffset_ff[ch];
    end
    if (xferPend_ff) begin
      nxt_actStab = stgStab_ff;
      nxt_actDiv = stgDiv_ff;
      nxt_actUser = stgUser_ff;
      for (int ch = 0; ch < 2; ch++) begin
        nxt_actPower[ch] = stgPower_ff[ch];
        nxt_actTest[ch] = stgTest_ff[ch];
        nxt_actOffset[ch] = stgOffset_ff[ch];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chanIdx_ff <= afc_pkg::RST_CHAN_INDEX[1:0];
      xferPend_ff <= 1'b0;
      stgStab_ff <= afc_pkg::RST_CLK_STAB;
      stgDiv_ff <= afc_pkg::RST_CLK_DIV;
      stgUser_ff <= {afc_pkg::RST_USER, afc_pkg::RST_USER};
      actStab_ff <= afc_pkg::RST_CLK_STAB;
      actDiv_ff <= afc_pkg::RST_CLK_DIV;
      actUser_ff <= {afc_pkg::RST_USER, afc_pkg::RST_USER};
      applied_ff <= 1'b0;
      for (int ch = 0; ch < 2; ch++) begin
        stgPower_ff[ch] <= afc_pkg::RST_POWER;
        stgTest_ff[ch] <= afc_pkg::RST_TEST;
        stgOffset_ff[ch] <= afc_pkg::RST_OFFSET;
        actPower_ff[ch] <= afc_pkg::RST_POWER;
        actTest_ff[ch] <= afc_pkg::RST_TEST;
        actOffset_ff[ch] <= afc_pkg::RST_OFFSET;
      end
    end else begin
      chanIdx_ff <= nxt_chanIdx;
      xferPend_ff <= nxt_xferPend;
      stgStab_ff <= nxt_stgStab;
      stgDiv_ff <= nxt_stgDiv;
      stgUser_ff <= nxt_stgUser;
      actStab_ff <= nxt_actStab;
      actDiv_ff <= nxt_actDiv;
      actUser_ff <= nxt_actUser;
      applied_ff <= nxt_applied;
      for (int ch = 0; ch < 2; ch++) begin
        stgPower_ff[ch] <= nxt_stgPower[ch];
        stgTest_ff[ch] <= nxt_stgTest[ch];
        stgOffset_ff[ch] <= nxt_stgOffset[ch];
        actPower_ff[ch] <= nxt_actPower[ch];
        actTest_ff[ch] <= nxt_actTest[ch];
        actOffset_ff[ch] <= nxt_actOffset[ch];
      end
    end
  end

  // ==========================================
  // Read back of staged values
  always_comb begin
    nxt_regRdData = regRdData_ff;
    if (regRdStb) begin
      case (regAddr)
        afc_pkg::ADDR_CHAN_INDEX: nxt_regRdData = {6'h00, chanIdx_ff};
        afc_pkg::ADDR_POWER: begin
          nxt_regRdData = afc_pkg::afc_pick_chan(chanIdx_ff, stgPower_ff[0], stgPower_ff[1]);
        end
        afc_pkg::ADDR_TEST: begin
          nxt_regRdData = afc_pkg::afc_pick_chan(chanIdx_ff, stgTest_ff[0], stgTest_ff[1]);
        end
        afc_pkg::ADDR_OFFSET: begin
          nxt_regRdData = afc_pkg::afc_pick_chan(chanIdx_ff, stgOffset_ff[0], stgOffset_ff[1]);
        end
        afc_pkg::ADDR_CLK_STAB: nxt_regRdData = stgStab_ff;
        afc_pkg::ADDR_CLK_DIV: nxt_regRdData = stgDiv_ff;
        afc_pkg::ADDR_USER_LSB: nxt_regRdData = stgUser_ff[7:0];
        afc_pkg::ADDR_USER_MSB: nxt_regRdData = stgUser_ff[15:8];
        afc_pkg::ADDR_TRANSFER: nxt_regRdData = {7'h00, xferPend_ff};
        default: nxt_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdData_ff <= 8'h00;
    end else begin
      regRdData_ff <= nxt_regRdData;
    end
  end

  // ==========================================
  // Power-down pin synchroniser and power mode outputs
  logic [2:0] pdSync_ff;
  logic [2:0] nxt_pdSync;
  logic pdLevel_ff;
  logic nxt_pdLevel;
  logic [1:0] pwrMode_ff [2];
  logic [1:0] nxt_pwrMode [2];

  always_comb begin
    nxt_pdSync = {pdSync_ff[1:0], pdPin};
    nxt_pdLevel = pdLevel_ff;
    if (pdSync_ff[1] == pdSync_ff[2]) begin
      nxt_pdLevel = pdSync_ff[2];
    end
    for (int ch = 0; ch < 2; ch++) begin
      if (pdLevel_ff) begin
        nxt_pwrMode[ch] = actPower_ff[ch][afc_pkg::PWR_PIN_BIT] ?
                          afc_pkg::PWR_STANDBY : afc_pkg::PWR_DOWN;
      end else begin
        case (actPower_ff[ch][afc_pkg::PWR_MODE_LSB +: 2])
          afc_pkg::PWR_DOWN: nxt_pwrMode[ch] = afc_pkg::PWR_DOWN;
          afc_pkg::PWR_STANDBY: nxt_pwrMode[ch] = afc_pkg::PWR_STANDBY;
          default: nxt_pwrMode[ch] = afc_pkg::PWR_NORMAL;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pdSync_ff <= 3'h0;
      pdLevel_ff <= 1'b0;
      pwrMode_ff[0] <= afc_pkg::PWR_NORMAL;
      pwrMode_ff[1] <= afc_pkg::PWR_NORMAL;
    end else begin
      pdSync_ff <= nxt_pdSync;
      pdLevel_ff <= nxt_pdLevel;
      pwrMode_ff[0] <= nxt_pwrMode[0];
      pwrMode_ff[1] <= nxt_pwrMode[1];
    end
  end

  // ==========================================
  // Clock divider, phase delay and stabiliser enable
  logic [2:0] divRatio;
  logic [2:0] divPhase;
  logic [2:0] divCnt_ff;
  logic [2:0] nxt_divCnt;
  logic [6:0] divLine_ff;
  logic [6:0] nxt_divLine;
  logic divTick;
  logic divClk_ff;
  logic nxt_divClk;
  logic dcs_ff;
  logic nxt_dcs;

  assign divRatio = actDiv_ff[afc_pkg::DIV_RATIO_LSB +: 3];
  assign divPhase = actDiv_ff[afc_pkg::DIV_PHASE_LSB +: 3];
  assign divTick = (divCnt_ff == 3'h0);

  always_comb begin
    if (applied_ff || divCnt_ff >= divRatio) begin
      nxt_divCnt = 3'h0;
    end else begin
      nxt_divCnt = divCnt_ff + 3'h1;
    end
    nxt_divLine = {divLine_ff[5:0], divTick};
    if (divPhase == 3'h0) begin
      nxt_divClk = divTick;
    end else begin
      nxt_divClk = divLine_ff[divPhase - 3'h1];
    end
    nxt_dcs = actStab_ff[afc_pkg::DCS_BIT] || (divRatio != 3'h0);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      divCnt_ff <= 3'h0;
      divLine_ff <= 7'h00;
      divClk_ff <= 1'b0;
      dcs_ff <= afc_pkg::RST_CLK_STAB[afc_pkg::DCS_BIT];
    end else begin
      divCnt_ff <= nxt_divCnt;
      divLine_ff <= nxt_divLine;
      divClk_ff <= nxt_divClk;
      dcs_ff <= nxt_dcs;
    end
  end

  // ==========================================
  // Channel data paths
  afc_chan_if chA ();
  afc_chan_if chB ();

  assign chA.testCtl = actTest_ff[0];
  assign chA.offset = actOffset_ff[0][afc_pkg::OFFSET_LSB +: 6];
  assign chA.userPat = actUser_ff;
  assign chA.restart = applied_ff;
  assign chB.testCtl = actTest_ff[1];
  assign chB.offset = actOffset_ff[1][afc_pkg::OFFSET_LSB +: 6];
  assign chB.userPat = actUser_ff;
  assign chB.restart = applied_ff;

  afc_channel_path pathA (
    .core_clk(core_clk),
    .reset(reset),
    .cfg(chA),
    .sampleIn(sampleA),
    .dataOut(dataOutA)
  );

  afc_channel_path pathB (
    .core_clk(core_clk),
    .reset(reset),
    .cfg(chB),
    .sampleIn(sampleB),
    .dataOut(dataOutB)
  );

  // ==========================================
  // Outputs
  assign regRdData = regRdData_ff;
  assign pwrModeA = pwrMode_ff[0];
  assign pwrModeB = pwrMode_ff[1];
  assign dcsEnable = dcs_ff;
  assign divClkOut = divClk_ff;
endmodule

// >>> afc_host_model.sv
// Host model that drives the register port of the configuration block
`timescale 1ns/10ps
module afc_host_model (
  input wire logic core_clk,
  input wire logic [7:0] regRdData,
  output logic regWrStb,
  output logic regRdStb,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData
);
  initial begin
    regWrStb = 1'h0;
    regRdStb = 1'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // ==========================================
  // Bus cycles
  // Strobe stands over one rising edge; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regWrStb = 1'h1;
    regAddr = a;
    regWrData = d;
    @(negedge core_clk);
    regWrStb = 1'h0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  // Read data is registered at the taking edge and sampled after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regRdStb = 1'h1;
    regAddr = a;
    @(negedge core_clk);
    regRdStb = 1'h0;
    regAddr = ~a;
    d = regRdData;
  endtask
endmodule

// >>> afc_function_config_monitor.sv
// Concurrent checks on the ports of the function configuration block
`timescale 1ns/10ps
module afc_function_config_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic pdPin,
  input wire logic [1:0] pwrModeA,
  input wire logic [1:0] pwrModeB,
  input wire logic dcsEnable,
  input wire logic divClkOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ==========================================
  // Properties
  property p_resetDefaults;
    $fell(reset) |-> dcsEnable && pwrModeA == 2'h0 ##1 divClkOut;
  endproperty
  a_resetDefaults: assert property (p_resetDefaults) else $error("bad state after reset");

  property p_xferReadBit;
    regRdStb && regAddr == afc_pkg::ADDR_TRANSFER |=> regRdData[7:1] == 7'h00;
  endproperty
  a_xferReadBit: assert property (p_xferReadBit) else $error("transfer read not clear");

  property p_pwrNoReserved;
    pwrModeA != 2'h3 && pwrModeB != 2'h3;
  endproperty
  a_pwrNoReserved: assert property (p_pwrNoReserved) else $error("reserved power mode");

  property p_dcsWhenDivided;
    $fell(divClkOut) |=> dcsEnable;
  endproperty
  a_dcsWhenDivided: assert property (p_dcsWhenDivided) else $error("stabiliser off");

  property p_pinToPower;
    $rose(pdPin) |-> ##[2:7] pwrModeA != 2'h0;
  endproperty
  a_pinToPower: assert property (p_pinToPower) else $error("pin ignored");

  property p_pinNotEarly;
    $rose(pdPin) && pwrModeA == 2'h0 |=> pwrModeA == 2'h0;
  endproperty
  a_pinNotEarly: assert property (p_pinNotEarly) else $error("pin taken unsynced");

  property p_rdHold;
    !regRdStb |=> $stable(regRdData);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");

  property p_indexRead;
    regWrStb && regAddr == afc_pkg::ADDR_CHAN_INDEX ##2
      regRdStb && regAddr == afc_pkg::ADDR_CHAN_INDEX
      |=> regRdData == ($past(regWrData, 3) & 8'h03);
  endproperty
  a_indexRead: assert property (p_indexRead) else $error("index not immediate");

  c_pinRise: cover property ($rose(pdPin));
  c_divStrobe: cover property ($fell(divClkOut));
  c_xferWrite: cover property (regWrStb && regAddr == afc_pkg::ADDR_TRANSFER);
endmodule

bind afc_function_config afc_function_config_monitor afc_function_config_monitor_i (
  .core_clk(core_clk),
  .reset(reset),
  .regWrStb(regWrStb),
  .regRdStb(regRdStb),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .pdPin(pdPin),
  .pwrModeA(pwrModeA),
  .pwrModeB(pwrModeB),
  .dcsEnable(dcsEnable),
  .divClkOut(divClkOut)
);

// >>> afc_function_config_bench.sv
// Self-checking bench for the function configuration register bank
`timescale 1ns/10ps
module afc_function_config_bench;
  typedef struct {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdat;
    logic [7:0] exp;
  } afc_row_s;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic pdPin = 1'h0;
  logic [11:0] sampleA = 12'h100;
  logic [11:0] sampleB = 12'h7F0;
  logic regWrStb;
  logic regRdStb;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic [11:0] dataOutA;
  logic [11:0] dataOutB;
  logic [1:0] pwrModeA;
  logic [1:0] pwrModeB;
  logic dcsEnable;
  logic divClkOut;
  logic [7:0] rdv;
  logic [11:0] d0;
  int n;
  int first [2];
  int n_errors = 0;
  int checked = 0;
  logic [7:0] pnHold [2] = '{8'h26, 8'h15};
  afc_row_s rows [12] = '{'{8'h05, 1'h0, 8'h00, 8'h03}, '{8'h08, 1'h0, 8'h00, 8'h00},
    '{8'h09, 1'h0, 8'h00, 8'h01}, '{8'h0B, 1'h0, 8'h00, 8'h00}, '{8'h0D, 1'h0, 8'h00, 8'h00},
    '{8'h10, 1'h0, 8'h00, 8'h00}, '{8'h19, 1'h0, 8'h00, 8'h00}, '{8'h1A, 1'h0, 8'h00, 8'h00},
    '{8'hFF, 1'h0, 8'h00, 8'h00}, '{8'h20, 1'h0, 8'h00, 8'h00}, '{8'h1A, 1'h1, 8'h5A, 8'h5A},
    '{8'h20, 1'h1, 8'h55, 8'h00}};

  afc_function_config afc_function_config_i (.core_clk(core_clk), .reset(reset),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .pdPin(pdPin), .sampleA(sampleA), .sampleB(sampleB),
    .dataOutA(dataOutA), .dataOutB(dataOutB), .pwrModeA(pwrModeA), .pwrModeB(pwrModeB),
    .dcsEnable(dcsEnable), .divClkOut(divClkOut));
  afc_host_model afc_host_model_i (.core_clk(core_clk), .regRdData(regRdData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regAddr(regAddr), .regWrData(regWrData));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================
  // Helpers
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Transfer, then wait until staged values reach the outputs
  task automatic xfer();
    afc_host_model_i.wr(8'hFF, 8'h01);
    repeat (4) @(negedge core_clk);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'h0;
    @(negedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        afc_host_model_i.wr(rows[i].addr, rows[i].wdat);
      end
      afc_host_model_i.rd(rows[i].addr, rdv);
      check({4'h0, rdv}, {4'h0, rows[i].exp});
    end
    afc_host_model_i.wr(8'h10, 8'h1F);
    check(dataOutA, 12'h100);
    xfer();
    check(dataOutA, 12'h11F);
    check(dataOutB, 12'h7FF);
    afc_host_model_i.rd(8'hFF, rdv);
    check({4'h0, rdv}, 12'h000);
    afc_host_model_i.wr(8'h10, 8'h20);
    xfer();
    check(dataOutA, 12'h0E0);
    afc_host_model_i.wr(8'h05, 8'h01);
    afc_host_model_i.rd(8'h05, rdv);
    check({4'h0, rdv}, 12'h001);
    afc_host_model_i.wr(8'h10, 8'h05);
    xfer();
    check(dataOutA, 12'h105);
    check(dataOutB, 12'h7D0);
    afc_host_model_i.wr(8'h05, 8'h03);
    afc_host_model_i.wr(8'h0D, 8'h07);
    xfer();
    d0 = dataOutA;
    @(negedge core_clk);
    check({11'h000, d0 == 12'hFFF || d0 == 12'h000}, 12'h001);
    check(dataOutA, ~d0);
    foreach (pnHold[i]) begin
      afc_host_model_i.wr(8'h0D, pnHold[i]);
      xfer();
      check(dataOutA, 12'hFFF);
      @(negedge core_clk);
      check(dataOutA, 12'hFFF);
      afc_host_model_i.wr(8'h0D, pnHold[i] & 8'h0F);
      xfer();
      n = 0;
      while (dataOutA === 12'hFFF && n < 30) begin
        @(negedge core_clk);
        n++;
      end
      check({11'h000, n < 30}, 12'h001);
    end
    afc_host_model_i.wr(8'h0D, 8'h03);
    xfer();
    check(dataOutA, 12'h000);
    afc_host_model_i.wr(8'h19, 8'hCD);
    afc_host_model_i.wr(8'h1A, 8'hAB);
    afc_host_model_i.wr(8'h0D, 8'h08);
    xfer();
    for (int k = 0; k < 3; k++) begin
      check(dataOutA, 12'hABC);
      @(negedge core_clk);
    end
    afc_host_model_i.wr(8'h0D, 8'h88);
    xfer();
    check(dataOutA, 12'h000);
    for (int c = 0; c < 4; c++) begin
      afc_host_model_i.wr(8'h08, 8'(c));
      xfer();
      check({10'h000, pwrModeA}, 12'(c == 3 ? 0 : c));
      check({10'h000, pwrModeB}, 12'(c == 3 ? 0 : c));
    end
    for (int k = 0; k < 2; k++) begin
      afc_host_model_i.wr(8'h08, k == 0 ? 8'h00 : 8'h20);
      xfer();
      pdPin = 1'h1;
      repeat (8) @(negedge core_clk);
      check({10'h000, pwrModeA}, 12'(k + 1));
      pdPin = 1'h0;
      repeat (8) @(negedge core_clk);
      check({10'h000, pwrModeA}, 12'h000);
    end
    afc_host_model_i.wr(8'h09, 8'h00);
    xfer();
    check({11'h000, dcsEnable}, 12'h000);
    check({11'h000, divClkOut}, 12'h001);
    for (int k = 0; k < 2; k++) begin
      afc_host_model_i.wr(8'h0B, k == 0 ? 8'h03 : 8'h1B);
      xfer();
      n = 0;
      while (divClkOut !== 1'h1 && n < 12) begin
        @(negedge core_clk);
        n++;
      end
      first[k] = n;
      check({11'h000, n < 12}, 12'h001);
      check({11'h000, dcsEnable}, 12'h001);
      for (int j = 0; j < 3; j++) begin
        @(negedge core_clk);
        check({11'h000, divClkOut}, 12'h000);
      end
      @(negedge core_clk);
      check({11'h000, divClkOut}, 12'h001);
    end
    check(12'((first[1] - first[0] + 12) % 4), 12'h003);
    // Reset in mid-run brings staged and active values back to defaults
    reset = 1'h1;
    repeat (2) @(negedge core_clk);
    reset = 1'h0;
    @(negedge core_clk);
    check(dataOutA, 12'h100);
    afc_host_model_i.rd(8'h09, rdv);
    check({4'h0, rdv}, 12'h001);
    tally_and_finish();
  end
endmodule
